/* File: hw/ppp_pkg.sv */
package ppp_pkg;

    // Pin-level widths of the programming port
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;

    // Legal programming windows for the two capacity variants
    localparam logic [14:0] SMALL_LO = 15'h6000;
    localparam logic [14:0] LARGE_LO = 15'h4000;
    localparam logic [14:0] AREA_HI  = 15'h7fff;

    // Phase counter loads in clock cycles, each phase lasts one cycle more (plain defaults, no timing printed)
    localparam logic [7:0] SETUP_CYC  = 8'h04;
    localparam logic [7:0] STROBE_CYC = 8'h08;
    localparam logic [7:0] HOLD_CYC   = 8'h04;

    // Command codes from the user side
    typedef enum logic [1:0] {
        PPP_CMD_READ,
        PPP_CMD_WRITE,
        PPP_CMD_VERIFY
    } ppp_cmd_e;

    // Pins toward the device, all driven by the programmer
    typedef struct packed {
        logic              reset_n;
        logic              ce_n;
        logic              oe_n;
        logic              vpp_on;
        logic [ADDR_W-1:0] addr;
    } ppp_pins_s;

endpackage : ppp_pkg

/* File: hw/ppp_programmer.sv */
`timescale 1ns/100ps

// Contract
// - The programmer holds the device reset pin low and runs the chip at normal supply while accessing the PROM.
// - Program mode is entered with output enable high and programming voltage applied.
// - Address and write data are presented together before the write strobe.
// - In program mode with stable address and data, pulling chip enable low stores the byte.
// - For the small variant only addresses 6000 to 7FFF hex may be programmed.
// - For the large variant only addresses 4000 to 7FFF hex may be programmed.
// - Programming of the one-time part should be followed by a read-back check.
module ppp_programmer
    import ppp_pkg::*;
#(
    parameter bit LARGE = 1'b1
)
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_req,
    input  wire ppp_cmd_e          i_cmd,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [DATA_W-1:0] i_d_in,
    output logic [DATA_W-1:0]      o_d_out,
    output logic                   o_d_oe,
    output ppp_pins_s              o_pins,
    output logic                   o_busy,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata,
    output logic                   o_range_err,
    output logic                   o_mismatch
);

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} ppp_state_e;

    ppp_state_e        state_ff;
    ppp_cmd_e          cmd_ff;
    logic [7:0]        cnt_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] last_wr_ff;
    logic              have_wr_ff;
    logic [ADDR_W-1:0] last_addr_ff;

    // Address window check for the selected variant
    wire logic [14:0] area_lo   = LARGE ? LARGE_LO : SMALL_LO;
    wire logic        in_range  = (i_addr >= area_lo) && (i_addr <= AREA_HI);
    wire logic        start     = i_req && (state_ff == ST_IDLE);
    wire logic        reject    = start && (i_cmd == PPP_CMD_WRITE) && !in_range;
    wire logic        cnt_zero  = (cnt_ff == 8'h00);
    wire logic        is_wr     = (cmd_ff == PPP_CMD_WRITE);
    wire logic        uses_vpp  = (cmd_ff != PPP_CMD_READ);
    // Verify is compared against the last byte written, only if that write was to the same address
    wire logic        chk_miss  = have_wr_ff && (last_addr_ff == addr_ff)
                                  && (i_d_in != last_wr_ff);

    // Sequencer: setup with pins stable, strobe phase, then hold
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_ff     <= ST_IDLE;
            cmd_ff       <= PPP_CMD_READ;
            cnt_ff       <= 8'h00;
            addr_ff      <= '0;
            wdata_ff     <= '0;
            o_done       <= 1'b0;
            o_rdata      <= '0;
            o_range_err  <= 1'b0;
            o_mismatch   <= 1'b0;
            last_wr_ff   <= '0;
            last_addr_ff <= '0;
            have_wr_ff   <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (reject)
                    begin
                        o_range_err <= 1'b1;
                        o_done      <= 1'b1;
                    end
                    else if (start)
                    begin
                        cmd_ff      <= i_cmd;
                        addr_ff     <= i_addr;
                        wdata_ff    <= i_wdata;
                        o_range_err <= 1'b0;
                        o_mismatch  <= 1'b0;
                        cnt_ff      <= SETUP_CYC;
                        state_ff    <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    if (cnt_zero)
                    begin
                        cnt_ff   <= STROBE_CYC;
                        state_ff <= ST_STROBE;
                    end
                    else
                        cnt_ff <= cnt_ff - 8'h01;
                end
                ST_STROBE:
                begin
                    if (cnt_zero)
                    begin
                        if (!is_wr)
                            o_rdata <= i_d_in; // Sample at end of strobe
                        if (cmd_ff == PPP_CMD_VERIFY)
                            o_mismatch <= chk_miss;
                        if (is_wr)
                        begin
                            last_wr_ff   <= wdata_ff;
                            last_addr_ff <= addr_ff;
                            have_wr_ff   <= 1'b1;
                        end
                        cnt_ff   <= HOLD_CYC;
                        state_ff <= ST_HOLD;
                    end
                    else
                        cnt_ff <= cnt_ff - 8'h01;
                end
                ST_HOLD:
                begin
                    if (cnt_zero)
                    begin
                        o_done   <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                    else
                        cnt_ff <= cnt_ff - 8'h01;
                end
            endcase
        end
    end

    // Pin levels per phase; idle leaves both enables high so data floats
    wire logic active   = (state_ff != ST_IDLE);
    wire logic strobing = (state_ff == ST_STROBE);
    wire logic nxt_ce_n = !(strobing && (cmd_ff != PPP_CMD_VERIFY));
    wire logic nxt_oe_n = !(strobing && !is_wr);
    wire logic nxt_vpp  = active && uses_vpp;
    wire logic nxt_d_oe = active && is_wr; // Drive only while device is in input mode

    // Registered pin outputs; device reset held low throughout
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_pins  <= '{reset_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1, vpp_on: 1'b0, addr: '0};
            o_d_out <= '0;
            o_d_oe  <= 1'b0;
            o_busy  <= 1'b0;
        end
        else
        begin
            o_pins.reset_n <= 1'b0;
            o_pins.ce_n    <= nxt_ce_n;
            o_pins.oe_n    <= nxt_oe_n;
            o_pins.vpp_on  <= nxt_vpp;
            o_pins.addr    <= addr_ff;
            o_d_out        <= wdata_ff;
            o_d_oe         <= nxt_d_oe;
            o_busy         <= active || (start && !reject); // Refused writes never look busy
        end
    end

    // Write strobe only with output enable high and programming voltage on
    write_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!o_pins.ce_n && o_pins.vpp_on) |-> o_pins.oe_n)
        else $error("write strobe without output enable high");
    // Data driven whenever the write strobe is low
    write_data_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!o_pins.ce_n && o_pins.oe_n) |-> o_d_oe)
        else $error("write strobe without data driven");
    // Count low cycles of output enable; a counter keeps the strobe check cheap to evaluate
    logic [7:0] oe_low_cnt_ff;
    wire logic [7:0] strobe_full = STROBE_CYC + 8'h01; // Strobe phase counts down through zero

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            oe_low_cnt_ff <= 8'h00;
        else if (!o_pins.oe_n)
            oe_low_cnt_ff <= oe_low_cnt_ff + 8'h01;
        else
            oe_low_cnt_ff <= 8'h00;
    end

    // Strobe lasts exactly the strobe phase, STROBE_CYC plus one cycles
    strobe_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_pins.oe_n) |-> (oe_low_cnt_ff == strobe_full))
        else $error("read strobe length wrong");
    // Strobe never runs past its phase
    strobe_cap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (oe_low_cnt_ff <= strobe_full))
        else $error("read strobe too long");
    // Never fight the device while it drives
    no_fight_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_pins.oe_n |-> !o_d_oe)
        else $error("data driven during read");
    // Device reset pin always low
    reset_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_pins.reset_n)
        else $error("device reset released");
    // Out of range writes never strobe
    range_chk_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        reject |=> !o_busy ##1 o_pins.ce_n)
        else $error("out of range write started");
    // Idle pins float the bus without programming voltage
    idle_float_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_ff == ST_IDLE && !o_busy) |=> (o_pins.ce_n && o_pins.oe_n && !o_pins.vpp_on))
        else $error("idle pins not parked");
    // Writes strobe with both enables never low together
    write_strb_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(!o_pins.ce_n && !o_pins.oe_n && o_pins.vpp_on))
        else $error("illegal enable combination under vpp");

endmodule : ppp_programmer

/* File: bench/ppp_prom_model.sv */
`timescale 1ns/100ps

// Behavioural PROM device seen through the programming adapter
module ppp_prom_model
    import ppp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire ppp_pins_s         i_pins,
    input  wire logic [DATA_W-1:0] i_d_out,
    input  wire logic              i_d_oe,
    output logic [DATA_W-1:0]      o_d_in
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] flt_ff = 8'h5a;

    // Mode decode from the pin levels alone
    wire access    = (i_pins.reset_n === 1'b0);
    wire rd_drive  = access && !i_pins.vpp_on && !i_pins.ce_n && !i_pins.oe_n;
    wire vf_drive  = access && i_pins.vpp_on && i_pins.ce_n && !i_pins.oe_n;
    wire dev_drive = rd_drive || vf_drive;

    // Erased cells read as all ones
    initial
        for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'hff;

    // Undriven lines wander, so a stale byte never passes for a read
    always @(posedge i_clk) flt_ff <= ~flt_ff;

    // Store the wire level on falling chip enable in program mode
    always @(negedge i_pins.ce_n)
        if (access && i_pins.vpp_on && i_pins.oe_n) mem[i_pins.addr] <= o_d_in;

    // Resolved data wire; contention shows as unknown
    assign o_d_in = (i_d_oe && dev_drive) ? 8'hxx :
                    i_d_oe ? i_d_out : (dev_drive ? mem[i_pins.addr] : flt_ff);
endmodule : ppp_prom_model

/* File: bench/parallel_prom_program_port_tb_top.sv */
`timescale 1ns/100ps

module parallel_prom_program_port_tb_top
    import ppp_pkg::*;
;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0;
    ppp_cmd_e i_cmd = PPP_CMD_READ;
    logic [ADDR_W-1:0] i_addr = 15'h0000;
    logic [DATA_W-1:0] i_wdata = 8'h00, i_d_in, o_d_out, o_rdata;
    logic o_d_oe, o_busy, o_done, o_range_err, o_mismatch, strobed;
    ppp_pins_s o_pins;
    logic [DATA_W-1:0] sm_d_in, sm_d_out, sm_rdata;
    logic sm_d_oe, sm_range_err;
    ppp_pins_s sm_pins;
    int n_errors = 0, total_checks = 0;

    always #4 i_clk = ~i_clk;

    ppp_programmer u_ppp_programmer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
        .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata), .i_d_in(i_d_in),
        .o_d_out(o_d_out), .o_d_oe(o_d_oe), .o_pins(o_pins), .o_busy(o_busy),
        .o_done(o_done), .o_rdata(o_rdata), .o_range_err(o_range_err),
        .o_mismatch(o_mismatch));
    ppp_prom_model u_ppp_prom_model (.i_clk(i_clk), .i_pins(o_pins), .i_d_out(o_d_out),
        .i_d_oe(o_d_oe), .o_d_in(i_d_in));

    // Small variant runs alongside on the same requests
    ppp_programmer #(.LARGE(1'b0)) u_ppp_programmer_small (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_req(i_req), .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata), .i_d_in(sm_d_in),
        .o_d_out(sm_d_out), .o_d_oe(sm_d_oe), .o_pins(sm_pins), .o_busy(), .o_done(),
        .o_rdata(sm_rdata), .o_range_err(sm_range_err), .o_mismatch());
    ppp_prom_model u_ppp_prom_model_small (.i_clk(i_clk), .i_pins(sm_pins), .i_d_out(sm_d_out),
        .i_d_oe(sm_d_oe), .o_d_in(sm_d_in));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One operation; waits a bounded time for the done pulse
    task automatic op(input ppp_cmd_e c, input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        strobed = 1'b0;
        @(negedge i_clk);
        i_req = 1'b1;
        i_cmd = c;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_req = 1'b0;
        while (o_done !== 1'b1 && n < 60)
        begin
            if (o_pins.ce_n === 1'b0 || o_pins.oe_n === 1'b0) strobed = 1'b1;
            chk("reset pin", 16'h0000, {15'h0, o_pins.reset_n});
            @(negedge i_clk);
            n++;
        end
        chk("done", 16'h0001, {15'h0, o_done});
    endtask : op

    // Write, then read back and verify at the lowest legal address
    task automatic t_write_read();
        op(PPP_CMD_WRITE, LARGE_LO, 8'h3c);
        chk("range err", 16'h0000, {15'h0, o_range_err});
        op(PPP_CMD_READ, LARGE_LO, 8'h00);
        chk("read byte", 16'h003c, {8'h0, o_rdata});
        op(PPP_CMD_VERIFY, LARGE_LO, 8'h00);
        chk("verify byte", 16'h003c, {8'h0, o_rdata});
        chk("mismatch", 16'h0000, {15'h0, o_mismatch});
    endtask : t_write_read

    // Top boundary, then one below the window is refused with no strobe
    task automatic t_window();
        op(PPP_CMD_WRITE, AREA_HI, 8'ha5);
        op(PPP_CMD_VERIFY, AREA_HI, 8'h00);
        chk("top byte", 16'h00a5, {8'h0, o_rdata});
        chk("top mismatch", 16'h0000, {15'h0, o_mismatch});
        op(PPP_CMD_WRITE, LARGE_LO - 15'h0001, 8'h00);
        chk("low refuse", 16'h0001, {15'h0, o_range_err});
        chk("refuse busy", 16'h0000, {15'h0, o_busy});
        chk("low strobe", 16'h0000, {15'h0, strobed});
        op(PPP_CMD_READ, LARGE_LO - 15'h0001, 8'h00);
        chk("erased byte", 16'h00ff, {8'h0, o_rdata});
    endtask : t_window

    // Small variant refuses just below its window and accepts its lowest address
    task automatic t_small();
        op(PPP_CMD_WRITE, SMALL_LO - 15'h0001, 8'h11);
        chk("small refuse", 16'h0001, {15'h0, sm_range_err});
        chk("large accept", 16'h0000, {15'h0, o_range_err});
        op(PPP_CMD_WRITE, SMALL_LO, 8'h22);
        chk("small accept", 16'h0000, {15'h0, sm_range_err});
        op(PPP_CMD_VERIFY, SMALL_LO, 8'h00);
        chk("small byte", 16'h0022, {8'h0, sm_rdata});
    endtask : t_small

    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // Watchdog sized well beyond the ten operations
    initial
    begin
        #20000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_write_read();
        t_window();
        t_small();
        stop_test();
    end
endmodule : parallel_prom_program_port_tb_top
